//--- core/zqcal_engine.sv
// device-side impedance calibration engine driven by long and short commands
//
// How it works
// RULE1: long command runs engine, then transfers codes
// RULE2: first long gets init window, later oper
// RULE3: short command completes within short window
// RULE4: short command corrects within 64 cycles
// RULE5: controller keeps channel quiet during windows
// RULE6: calibration current path off when done
// RULE7: controller precharges all banks before command
// RULE8: controller waits exit time after self refresh
// RULE9: no recalibration on self-refresh exit
// RULE10: controller never overlaps shared resistor windows
// RULE11: controller holds clock enable high throughout
// RULE12: controller keeps termination disabled throughout
// RULE13: all data drivers high impedance throughout
// RULE14: controller tracks first flag and blocks commands
`include "zqcal_regs.svh"
`default_nettype none
module zqcal_engine #(
  parameter int INIT_NCK = `ZQCAL_TZQINIT_NCK,
  parameter int OPER_NCK = `ZQCAL_TZQOPER_NCK,
  parameter int CS_NCK   = `ZQCAL_TZQCS_NCK
) (
  input  wire logic                    mclk,
  input  wire logic                    nrst,
  input  wire logic                    zq_long,
  input  wire logic                    zq_short,
  input  wire logic                    sr_exit,
  input  wire logic                    cmp_pin,
  output logic                         cal_busy,
  output logic                         cal_current_en,
  output logic                         cal_done,
  output logic                         first_pending,
  output zqcal_pkg::zqcal_code_t       drv_code,
  output zqcal_pkg::zqcal_code_t       odt_code
);
  import zqcal_pkg::*;

  localparam int CW = $clog2(INIT_NCK + 1);

  // done shows one cycle after the transfer edge, so the full window plus one
  localparam int INIT_DONE = INIT_NCK + 1;
  localparam int OPER_DONE = OPER_NCK + 1;
  localparam int CS_DONE   = CS_NCK + 1;

  // window lengths must leave room for the transfer cycle
  initial begin
    if (CS_NCK < 2) begin
      $error("zqcal_engine: short window too small for run and transfer");
    end
    if (OPER_NCK < CS_NCK) begin
      $error("zqcal_engine: long window shorter than short window");
    end
    if (INIT_NCK < OPER_NCK) begin
      $error("zqcal_engine: first long window shorter than later ones");
    end
    if (CS_NCK > `ZQCAL_STEP_NCK) begin
      $error("zqcal_engine: short window beyond the correction bound");
    end
    // the window checks below use delay ranges, which stop at this length
    if (INIT_DONE > 1000) begin
      $error("zqcal_engine: first window too long for the checks");
    end
  end

  typedef struct packed {
    zqcal_state_e      st;
    logic [CW-1:0]     cnt;
    logic              first;
    logic              cmp_s1;
    logic              cmp_s2;
    logic              done;
    zqcal_code_t       eng;
    zqcal_code_t       drv;
    zqcal_code_t       odt;
  } zqcal_s;

  zqcal_s      s_reg;
  zqcal_s      s_next;
  zqcal_code_t step_code;
  logic        step_lim;

  zqcal_step u_step (
    .cmp_hi   (s_reg.cmp_s2),
    .code_in  (s_reg.eng),
    .at_limit (step_lim),
    .code_out (step_code)
  );

  function automatic logic [CW-1:0] win_len(input logic is_long, input logic is_first);
    win_len = is_long ? (is_first ? CW'(INIT_NCK) : CW'(OPER_NCK)) : CW'(CS_NCK);
  endfunction : win_len

  // sequencing: idle -> run (count window minus one) -> xfer (one cycle)
  always_comb begin
    s_next        = s_reg;
    s_next.cmp_s1 = cmp_pin;
    s_next.cmp_s2 = s_reg.cmp_s1;
    s_next.done   = 1'b0;
    unique case (s_reg.st)
      ZQCAL_IDLE: begin
        // sr_exit deliberately unused for starting: only commands start it [RULE9]
        if (zq_long || zq_short) begin
          s_next.st  = ZQCAL_RUN;                                  // [RULE1]
          s_next.cnt = win_len(zq_long, s_reg.first) - CW'(2);     // [RULE2] [RULE3]
          if (zq_long) begin
            s_next.first = 1'b0;
          end
        end
      end
      ZQCAL_RUN: begin
        s_next.eng = step_code;                                    // one lsb per cycle [RULE4]
        if (s_reg.cnt == '0) begin
          s_next.st = ZQCAL_XFER;
        end else begin
          s_next.cnt = s_reg.cnt - CW'(1);
        end
      end
      ZQCAL_XFER: begin
        s_next.drv  = s_reg.eng;                                   // results reach the io [RULE1]
        s_next.odt  = s_reg.eng;
        s_next.done = 1'b1;
        s_next.st   = ZQCAL_IDLE;                                  // busy drops; current path already off during xfer [RULE6]
      end
      default: s_next.st = ZQCAL_IDLE;
    endcase
  end

  // state register, synchronous reset restarts the first-command window
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_reg <= '{st:     ZQCAL_IDLE,
                 cnt:    '0,
                 first:  1'b1,             // next long command gets the init window
                 cmp_s1: 1'b0,
                 cmp_s2: 1'b0,
                 done:   1'b0,
                 eng:    `ZQCAL_CODE_RST,
                 drv:    `ZQCAL_CODE_RST,
                 odt:    `ZQCAL_CODE_RST};
    end else begin
      s_reg <= s_next;
    end
  end

  assign cal_busy       = s_reg.st != ZQCAL_IDLE;
  assign cal_current_en = s_reg.st == ZQCAL_RUN;                   // [RULE6]
  assign cal_done       = s_reg.done;
  assign first_pending  = s_reg.first;
  assign drv_code       = s_reg.drv;
  assign odt_code       = s_reg.odt;

  // window length check helper
  logic [CW:0] busy_cnt;
  always_ff @(posedge mclk) begin
    if (!nrst || !cal_busy) begin
      busy_cnt <= '0;
    end else begin
      busy_cnt <= busy_cnt + (CW+1)'(1);
    end
  end

  // an idle engine answers a command in the very next cycle
  property p_start(cmd);
    @(posedge mclk) disable iff (!nrst)
      (s_reg.st == ZQCAL_IDLE && cmd) |=> cal_busy && cal_current_en;
  endproperty
  long_start_a:   assert property (p_start(zq_long)) else $error("long command did not start"); // [RULE1]
  short_start_a:  assert property (p_start(zq_short)) else $error("short command did not start"); // [RULE3]

  // window lengths: codes and done land together on the window's last edge, sampled one cycle later
  // commands inside a window are dropped, so a new one cannot disturb these counts
  short_window_a: assert property (@(posedge mclk) disable iff (!nrst) // [RULE3]
    (s_reg.st == ZQCAL_IDLE && zq_short && !zq_long)
    |-> ##[CS_DONE:CS_DONE] (cal_done && busy_cnt == (CW+1)'(CS_NCK)))
    else $error("short window length wrong");
  first_window_a: assert property (@(posedge mclk) disable iff (!nrst) // [RULE2]
    (s_reg.st == ZQCAL_IDLE && zq_long && s_reg.first)
    |-> ##[INIT_DONE:INIT_DONE] (cal_done && busy_cnt == (CW+1)'(INIT_NCK)))
    else $error("first long window wrong");
  oper_window_a:  assert property (@(posedge mclk) disable iff (!nrst) // [RULE2]
    (s_reg.st == ZQCAL_IDLE && zq_long && !s_reg.first)
    |-> ##[OPER_DONE:OPER_DONE] (cal_done && busy_cnt == (CW+1)'(OPER_NCK)))
    else $error("later long window wrong");

  // first flag: cleared by a long command only, a short one leaves it
  first_clear_a:  assert property (@(posedge mclk) disable iff (!nrst) // [RULE2]
    (s_reg.st == ZQCAL_IDLE && zq_long) |=> !first_pending)
    else $error("first flag kept");
  first_keep_a:   assert property (@(posedge mclk) disable iff (!nrst) // [RULE2]
    (s_reg.st == ZQCAL_IDLE && zq_short && !zq_long) |=> first_pending == $past(first_pending))
    else $error("first flag cleared by short command");

  // io codes move only on the transfer edge and never while the engine runs
  xfer_codes_a:   assert property (@(posedge mclk) disable iff (!nrst) // [RULE1]
    $changed(drv_code) |-> $past(s_reg.st == ZQCAL_XFER) && drv_code == odt_code)
    else $error("codes moved outside transfer");
  io_hold_a:      assert property (@(posedge mclk) disable iff (!nrst) // [RULE1]
    (s_reg.st == ZQCAL_RUN) |=> $stable(drv_code) && $stable(odt_code))
    else $error("codes moved while running");

  // every run cycle away from a limit moves the engine code by one step
  step_bound_a:   assert property (@(posedge mclk) disable iff (!nrst) // [RULE4]
    (cal_current_en && !step_lim) |=> s_reg.eng != $past(s_reg.eng))
    else $error("no correction step");

  // current path off once results are in; self-refresh exit alone starts nothing
  current_off_a:  assert property (@(posedge mclk) disable iff (!nrst) // [RULE6]
    cal_done |-> !cal_current_en && !$past(cal_current_en))
    else $error("current path left on");
  no_self_cal_a:  assert property (@(posedge mclk) disable iff (!nrst) // [RULE9]
    (!cal_busy && sr_exit && !zq_long && !zq_short) |=> !cal_busy)
    else $error("calibrated on sr exit");

  // main scenarios: first long, later long, short, done, short after self-refresh exit
  cover_long_c:  cover property (@(posedge mclk) disable iff (!nrst) zq_long ##1 cal_busy);
  cover_oper_c:  cover property (@(posedge mclk) disable iff (!nrst)
    s_reg.st == ZQCAL_IDLE && zq_long && !s_reg.first);
  cover_short_c: cover property (@(posedge mclk) disable iff (!nrst) zq_short && !first_pending);
  cover_done_c:  cover property (@(posedge mclk) disable iff (!nrst) cal_done);
  cover_sr_c:    cover property (@(posedge mclk) disable iff (!nrst) sr_exit ##[1:20] zq_short);
endmodule : zqcal_engine
`default_nettype wire

//--- core/zqcal_regs.svh
// timing and field constants for the impedance calibration block
`ifndef ZQCAL_REGS_SVH
`define ZQCAL_REGS_SVH
`define ZQCAL_TZQINIT_NCK   512
`define ZQCAL_TZQOPER_NCK   256
`define ZQCAL_TZQCS_NCK     64
`define ZQCAL_STEP_NCK      64
`define ZQCAL_CODE_W        6
`define ZQCAL_CODE_RST      6'h20
`define ZQCAL_CODE_MAX      6'h3f
`endif

//--- core/zqcal_pkg.sv
// types shared by the impedance calibration block
`include "zqcal_regs.svh"
`default_nettype none
package zqcal_pkg;
  typedef enum logic [2:0] {
    ZQCAL_IDLE = 3'b001,
    ZQCAL_RUN  = 3'b010,
    ZQCAL_XFER = 3'b100
  } zqcal_state_e;
  typedef logic [`ZQCAL_CODE_W-1:0] zqcal_code_t;
endpackage : zqcal_pkg
`default_nettype wire

//--- core/zqcal_step.sv
// one up/down tracking step of one lsb of the impedance code
`include "zqcal_regs.svh"
`default_nettype none
module zqcal_step (
  input  wire logic                    cmp_hi,
  input  wire zqcal_pkg::zqcal_code_t  code_in,
  output logic                         at_limit,
  output zqcal_pkg::zqcal_code_t       code_out
);
  import zqcal_pkg::*;
  // saturate at the ends so a stuck comparator cannot wrap the code
  always_comb begin
    at_limit = cmp_hi ? (code_in == `ZQCAL_CODE_MAX) : (code_in == '0);
    if (at_limit) begin
      code_out = code_in;
    end else if (cmp_hi) begin
      code_out = code_in + zqcal_code_t'(1);
    end else begin
      code_out = code_in - zqcal_code_t'(1);
    end
  end
endmodule : zqcal_step
`default_nettype wire

//--- tb/zqcal_ctrl_model.sv
// controller model that issues calibration commands and keeps quiet windows
`default_nettype none
module zqcal_ctrl_model #(
  parameter int INIT_NCK = 8,
  parameter int OPER_NCK = 6,
  parameter int CS_NCK   = 4
) (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic req_long,
  input  wire logic req_short,
  output logic      zq_long,
  output logic      zq_short
);
  timeunit 1ns;
  timeprecision 1ps;
  logic first_reg;
  int   quiet_reg;
  // issue only on a quiet channel; banks idle and clock enable high are assumed
  assign zq_long  = req_long && (quiet_reg == 0);
  assign zq_short = req_short && !req_long && (quiet_reg == 0);
  // one device on its own resistor: windows never overlap by construction
  // termination held off and data bus released by this side; no such pins here
  // window covers the transfer cycle too, so the next command lands when done shows
  // first flag picks the window length; the window countdown blocks commands until expiry
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      first_reg <= 1'b1;
      quiet_reg <= 0;
    end else if (zq_long) begin
      first_reg <= 1'b0;
      quiet_reg <= first_reg ? INIT_NCK : OPER_NCK;
    end else if (zq_short) begin
      quiet_reg <= CS_NCK;
    end else if (quiet_reg != 0) begin
      quiet_reg <= quiet_reg - 1;
    end
  end
endmodule : zqcal_ctrl_model
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the impedance calibration engine
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import zqcal_pkg::*;
  localparam int INIT = 8;
  localparam int OPER = 6;
  localparam int CS   = 4;
  logic mclk = 0, nrst = 0, req_long = 0, req_short = 0, sr_exit = 0, cmp_pin = 1;
  logic zq_long, zq_short, cal_busy, cal_current_en, cal_done, first_pending;
  zqcal_code_t drv_code, odt_code, last_code;
  int miscompares = 0, num_checks = 0, b, c, d;
  zqcal_engine #(.INIT_NCK(INIT), .OPER_NCK(OPER), .CS_NCK(CS)) dut_u (.mclk(mclk), .nrst(nrst),
    .zq_long(zq_long), .zq_short(zq_short), .sr_exit(sr_exit), .cmp_pin(cmp_pin), .cal_busy(cal_busy),
    .cal_current_en(cal_current_en), .cal_done(cal_done), .first_pending(first_pending),
    .drv_code(drv_code), .odt_code(odt_code));
  zqcal_ctrl_model #(.INIT_NCK(INIT), .OPER_NCK(OPER), .CS_NCK(CS)) ctrl_u (.mclk(mclk), .nrst(nrst),
    .req_long(req_long), .req_short(req_short), .zq_long(zq_long), .zq_short(zq_short));
  initial begin
    forever #20 mclk = ~mclk;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  // one command, then count busy and current cycles up to the done pulse
  task automatic issue(input logic lng);
    b = 0;
    c = 0;
    d = 0;
    @(negedge mclk);
    req_long = lng;
    req_short = !lng;
    @(negedge mclk);
    req_long = 0;
    req_short = 0;
    for (int i = 1; i <= 40 && d == 0; i++) begin
      if (cal_busy === 1'b1) b++;
      if (cal_current_en === 1'b1) c++;
      if (cal_done === 1'b1) d = i;
      else @(negedge mclk);
    end
  endtask : issue
  task automatic test_long(input int n);
    last_code = drv_code;
    issue(1'b1);
    check("done_at", n + 1, d);
    check("busy_cycles", n, b);
    check("current_cycles", n - 1, c);
    check("drv_code", last_code + n - 1, drv_code);
    check("pending", 0, first_pending);
    check("odt_code", drv_code, odt_code);
    @(negedge mclk);
    check("current_off", 0, cal_current_en);
  endtask : test_long
  task automatic test_short();
    cmp_pin = 0;
    repeat (4) @(negedge mclk);
    last_code = drv_code;
    issue(1'b0);
    check("done_at", CS + 1, d);
    check("code_lower", 1, drv_code < last_code);
    check("drv_code", last_code - (CS - 1), drv_code);
    check("odt_code", drv_code, odt_code);
  endtask : test_short
  // self-refresh exit alone leaves the codes and engine untouched
  task automatic test_sr_exit();
    last_code = drv_code;
    @(negedge mclk);
    sr_exit = 1;
    for (int i = 0; i < 12; i++) begin
      @(negedge mclk);
      sr_exit = 0;
      check("sr_busy", 0, cal_busy);
    end
    check("sr_code", last_code, drv_code);
    // a short command once the exit time has passed is served normally
    issue(1'b0);
    check("sr_short_done", CS + 1, d);
    check("sr_short_code", last_code - (CS - 1), drv_code);
  endtask : test_sr_exit
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  initial begin
    #(2000 * 40);
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (16) @(negedge mclk);
    nrst = 1;
    check("rst_code", 6'h20, drv_code);
    check("rst_pending", 1, first_pending);
    test_long(INIT);
    check("code_raised", 1, drv_code > last_code);
    test_long(OPER);
    test_short();
    test_sr_exit();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
